// [rtl/smt_regs.sv]
// test and override register bank for modem, charge pump, vco and delta-sigma synthesizer
`timescale 1ns/100ps
module smt_regs #(
    parameter logic VCO_TYPE = 1'b0
) (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        resetn,
    // register access port
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [6:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    output logic [7:0]       reg_rdata,
    // analog and calibration status, asynchronous to clk_sys
    input  wire logic [4:0]  cp_corr_auto,
    input  wire logic [6:0]  vco_cal_auto,
    input  wire logic        vco_cal_done,
    input  wire logic        tx_mode,
    input  wire logic        vco_cal_pre_tx,
    // modem controls
    output logic             bcr_comp_bypass,
    output logic             slicer_comp_bypass,
    output logic             dither_signed,
    output logic             osc_detect_en,
    output logic [3:0]       ook_th_bits,
    output logic             ds_ref_from_xtal,
    output logic             ds_ref_invert,
    output logic             disc_toggle_en,
    // charge pump controls
    output logic             pfd_reset,
    output logic             fb_div_reset,
    output logic             cp_force_up,
    output logic             cp_force_dn,
    output logic             cp_dc_only,
    output logic [2:0]       cp_dc_current,
    output logic [1:0]       cp_gain,
    output logic [4:0]       cp_corr,
    // divider and vco trims
    output logic             fb_div_high_current,
    output logic [1:0]       div_three_trim,
    output logic [1:0]       div_two_trim,
    output logic [1:0]       div_one_half_trim,
    output logic [3:0]       vco_corr,
    output logic             vco_corr_override,
    output logic [1:0]       vco_cur,
    output logic [6:0]       vco_cal,
    // delta-sigma controls
    output logic             ds_dither_en,
    output logic             open_loop,
    output logic [16:0]      ds_modulus,
    output logic [1:0]       ds_order,
    output logic             ds_reset_mode,
    output logic             ds_reset
);

    logic [7:0] modem_test_control_reg;
    logic [7:0] charge_pump_test_control_reg;
    logic [7:0] charge_pump_trim_override_reg;
    logic [7:0] divider_trim_sigma_test_reg;
    logic [7:0] oscillator_current_trim_reg;
    logic [7:0] oscillator_cal_override_reg;
    logic [7:0] synthesizer_test_control_reg;

    // status synchronisers
    logic [4:0] cp_corr_s1_reg;
    logic [4:0] cp_corr_s2_reg;
    logic [6:0] vco_cal_s1_reg;
    logic [6:0] vco_cal_s2_reg;
    logic [2:0] flags_s1_reg;
    logic [2:0] flags_s2_reg;
    logic [4:0] cp_corr_s3_reg;
    logic [4:0] cp_corr_held_reg;
    logic [6:0] vco_cal_s3_reg;
    logic [6:0] vco_cal_held_reg;

    logic       boost_window;
    logic [4:0] cp_corr_next;
    logic [6:0] vco_cal_next;
    logic [3:0] vco_corr_next;
    logic [1:0] vco_cur_next;
    logic [7:0] reg_rdata_next;

    function automatic logic hit(input logic [6:0] a, input logic [6:0] base);
        hit = reg_wr && (a == base);
    endfunction : hit

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            cp_corr_s1_reg <= 5'h00;
            cp_corr_s2_reg <= 5'h00;
            vco_cal_s1_reg <= 7'h00;
            vco_cal_s2_reg <= 7'h00;
            flags_s1_reg   <= 3'h0;
            flags_s2_reg   <= 3'h0;
        end
        else
        begin
            cp_corr_s1_reg <= cp_corr_auto;
            cp_corr_s2_reg <= cp_corr_s1_reg;
            vco_cal_s1_reg <= vco_cal_auto;
            vco_cal_s2_reg <= vco_cal_s1_reg;
            flags_s1_reg   <= {vco_cal_done, tx_mode, vco_cal_pre_tx};
            flags_s2_reg   <= flags_s1_reg;
        end
    end

    // status words are taken only once two samples agree, so no torn word escapes
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            cp_corr_s3_reg   <= 5'h00;
            cp_corr_held_reg <= 5'h00;
            vco_cal_s3_reg   <= 7'h00;
            vco_cal_held_reg <= 7'h00;
        end
        else
        begin
            cp_corr_s3_reg <= cp_corr_s2_reg;
            vco_cal_s3_reg <= vco_cal_s2_reg;
            if (cp_corr_s2_reg == cp_corr_s3_reg)
                cp_corr_held_reg <= cp_corr_s3_reg;
            if (vco_cal_s2_reg == vco_cal_s3_reg)
                vco_cal_held_reg <= vco_cal_s3_reg;
        end
    end

    // register writes
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            modem_test_control_reg        <= smt_pkg::RST_MODEM_TEST;
            charge_pump_test_control_reg  <= smt_pkg::RST_CP_TEST;
            charge_pump_trim_override_reg <= smt_pkg::RST_CP_TRIM;
            divider_trim_sigma_test_reg   <= smt_pkg::RST_DIV_TRIM;
            oscillator_current_trim_reg   <= smt_pkg::RST_VCO_TRIM;
            oscillator_cal_override_reg   <= smt_pkg::RST_VCO_CAL;
            synthesizer_test_control_reg  <= smt_pkg::RST_SYNTH_TEST;
        end
        else
        begin
            if (hit(reg_addr, smt_pkg::ADDR_MODEM_TEST))
                modem_test_control_reg <= reg_wdata;
            if (hit(reg_addr, smt_pkg::ADDR_CP_TEST))
                charge_pump_test_control_reg <= reg_wdata;
            if (hit(reg_addr, smt_pkg::ADDR_CP_TRIM))
                charge_pump_trim_override_reg <= reg_wdata;
            if (hit(reg_addr, smt_pkg::ADDR_DIV_TRIM))
                divider_trim_sigma_test_reg <= reg_wdata;
            if (hit(reg_addr, smt_pkg::ADDR_VCO_TRIM))
                oscillator_current_trim_reg <= reg_wdata;
            if (hit(reg_addr, smt_pkg::ADDR_VCO_CAL))
                oscillator_cal_override_reg <= reg_wdata;
            if (hit(reg_addr, smt_pkg::ADDR_SYNTH_TEST))
            begin
                synthesizer_test_control_reg <= reg_wdata;
                // vco type bit is read only
                synthesizer_test_control_reg[smt_pkg::ST_VCO_TYPE] <= 1'b0;
            end
        end
    end

    // effective values of override-capable fields
    always_comb
    begin
        boost_window = flags_s2_reg[1] | flags_s2_reg[0];
        if (charge_pump_trim_override_reg[smt_pkg::CT_CORR_OV])
            cp_corr_next = charge_pump_trim_override_reg[smt_pkg::CT_CORR_HI:0];
        else
            cp_corr_next = cp_corr_held_reg;
        if (oscillator_cal_override_reg[smt_pkg::VC_OVR])
            vco_cal_next = oscillator_cal_override_reg[smt_pkg::VC_VAL_HI:0];
        else
            vco_cal_next = vco_cal_held_reg;
        if (divider_trim_sigma_test_reg[smt_pkg::DT_CORR_BOOST] && boost_window)
            vco_corr_next = smt_pkg::VCO_CORR_BOOST;
        else
            vco_corr_next =
                oscillator_current_trim_reg[smt_pkg::VT_CORR_HI:smt_pkg::VT_CORR_LO];
        if (oscillator_current_trim_reg[smt_pkg::VT_CUR_BOOST] && boost_window)
            vco_cur_next = smt_pkg::VCO_CUR_BOOST;
        else
            vco_cur_next = oscillator_current_trim_reg[smt_pkg::VT_CUR_HI:0];
    end

    // read mux
    always_comb
    begin
        reg_rdata_next = 8'h00;
        if (reg_addr == smt_pkg::ADDR_MODEM_TEST)
            reg_rdata_next = modem_test_control_reg;
        else if (reg_addr == smt_pkg::ADDR_CP_TEST)
            reg_rdata_next = charge_pump_test_control_reg;
        else if (reg_addr == smt_pkg::ADDR_CP_TRIM)
            reg_rdata_next = {
                charge_pump_trim_override_reg[smt_pkg::CT_GAIN_HI:smt_pkg::CT_CORR_OV],
                cp_corr_next};
        else if (reg_addr == smt_pkg::ADDR_DIV_TRIM)
            reg_rdata_next = divider_trim_sigma_test_reg;
        else if (reg_addr == smt_pkg::ADDR_VCO_TRIM)
            reg_rdata_next = oscillator_current_trim_reg;
        else if (reg_addr == smt_pkg::ADDR_VCO_CAL)
            reg_rdata_next = {flags_s2_reg[2], vco_cal_next};
        else if (reg_addr == smt_pkg::ADDR_SYNTH_TEST)
        begin
            reg_rdata_next = synthesizer_test_control_reg;
            reg_rdata_next[smt_pkg::ST_VCO_TYPE] = VCO_TYPE;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            reg_rdata <= 8'h00;
        else if (reg_rd)
            reg_rdata <= reg_rdata_next;
    end

    // modem outputs
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            bcr_comp_bypass    <= 1'b0;
            slicer_comp_bypass <= 1'b0;
            dither_signed      <= 1'b0;
            osc_detect_en      <= 1'b1;
            ook_th_bits        <= smt_pkg::OOK_TH_SHORT;
            ds_ref_from_xtal   <= 1'b0;
            ds_ref_invert      <= 1'b0;
            disc_toggle_en     <= 1'b0;
        end
        else
        begin
            bcr_comp_bypass    <= modem_test_control_reg[smt_pkg::MT_BCR_BYP];
            slicer_comp_bypass <= modem_test_control_reg[smt_pkg::MT_SLIC_BYP];
            dither_signed      <= modem_test_control_reg[smt_pkg::MT_DITH_TYPE];
            osc_detect_en      <= !modem_test_control_reg[smt_pkg::MT_OSC_DIS];
            ook_th_bits        <= modem_test_control_reg[smt_pkg::MT_OOK_TH] ?
                                  smt_pkg::OOK_TH_LONG : smt_pkg::OOK_TH_SHORT;
            ds_ref_from_xtal   <= modem_test_control_reg[smt_pkg::MT_REF_SEL];
            ds_ref_invert      <= modem_test_control_reg[smt_pkg::MT_REF_INV];
            disc_toggle_en     <= modem_test_control_reg[smt_pkg::MT_DISC_TOGG];
        end
    end

    // charge pump outputs
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            pfd_reset     <= 1'b0;
            fb_div_reset  <= 1'b0;
            cp_force_up   <= 1'b0;
            cp_force_dn   <= 1'b0;
            cp_dc_only    <= 1'b0;
            cp_dc_current <= 3'h0;
            cp_gain       <= smt_pkg::RST_CP_TRIM[smt_pkg::CT_GAIN_HI:smt_pkg::CT_GAIN_LO];
            cp_corr       <= 5'h00;
        end
        else
        begin
            pfd_reset     <= charge_pump_test_control_reg[smt_pkg::CP_PFD_RST];
            fb_div_reset  <= charge_pump_test_control_reg[smt_pkg::CP_FB_RST];
            cp_force_up   <= charge_pump_test_control_reg[smt_pkg::CP_FORCE_UP];
            cp_force_dn   <= charge_pump_test_control_reg[smt_pkg::CP_FORCE_DN];
            cp_dc_only    <= charge_pump_test_control_reg[smt_pkg::CP_DC_ONLY];
            cp_dc_current <= charge_pump_test_control_reg[smt_pkg::CP_DC_CUR_HI:0];
            cp_gain       <=
                charge_pump_trim_override_reg[smt_pkg::CT_GAIN_HI:smt_pkg::CT_GAIN_LO];
            cp_corr       <= cp_corr_next;
        end
    end

    // divider and vco outputs
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            fb_div_high_current <= 1'b0;
            div_three_trim      <= 2'h0;
            div_two_trim        <= 2'h0;
            div_one_half_trim   <= 2'h0;
            vco_corr            <= 4'h0;
            vco_corr_override   <= 1'b0;
            vco_cur             <= smt_pkg::RST_VCO_TRIM[smt_pkg::VT_CUR_HI:0];
            vco_cal             <= 7'h00;
        end
        else
        begin
            fb_div_high_current <= divider_trim_sigma_test_reg[smt_pkg::DT_FB_HC];
            div_three_trim      <=
                divider_trim_sigma_test_reg[smt_pkg::DT_D3_LO +: 2];
            div_two_trim        <=
                divider_trim_sigma_test_reg[smt_pkg::DT_D2_LO +: 2];
            div_one_half_trim   <=
                divider_trim_sigma_test_reg[smt_pkg::DT_D15_LO +: 2];
            vco_corr            <= vco_corr_next;
            vco_corr_override   <= oscillator_current_trim_reg[smt_pkg::VT_CORR_OV]
                                   | (divider_trim_sigma_test_reg[smt_pkg::DT_CORR_BOOST]
                                      & boost_window);
            vco_cur             <= vco_cur_next;
            vco_cal             <= vco_cal_next;
        end
    end

    // delta-sigma outputs
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            ds_dither_en  <= 1'b0;
            open_loop     <= 1'b0;
            ds_modulus    <= smt_pkg::MODULUS_DEC;
            ds_order      <= smt_pkg::RST_SYNTH_TEST[smt_pkg::ST_ORDER_HI:smt_pkg::ST_ORDER_LO];
            ds_reset_mode <= 1'b1;
            ds_reset      <= 1'b0;
        end
        else
        begin
            ds_dither_en  <= synthesizer_test_control_reg[smt_pkg::ST_DITH_EN];
            open_loop     <= synthesizer_test_control_reg[smt_pkg::ST_OPEN_LOOP];
            ds_modulus    <= synthesizer_test_control_reg[smt_pkg::ST_MODULUS] ?
                             smt_pkg::MODULUS_BIN : smt_pkg::MODULUS_DEC;
            ds_order      <=
                synthesizer_test_control_reg[smt_pkg::ST_ORDER_HI:smt_pkg::ST_ORDER_LO];
            ds_reset_mode <= synthesizer_test_control_reg[smt_pkg::ST_RST_MODE];
            ds_reset      <= synthesizer_test_control_reg[smt_pkg::ST_RST];
        end
    end

endmodule : smt_regs

// [rtl/smt_pkg.sv]
// package: register map, field positions and reset values of the synth/modem test bank
package smt_pkg;
    // register offsets
    localparam logic [6:0] ADDR_MODEM_TEST  = 7'h56;
    localparam logic [6:0] ADDR_CP_TEST     = 7'h57;
    localparam logic [6:0] ADDR_CP_TRIM     = 7'h58;
    localparam logic [6:0] ADDR_DIV_TRIM    = 7'h59;
    localparam logic [6:0] ADDR_VCO_TRIM    = 7'h5A;
    localparam logic [6:0] ADDR_VCO_CAL     = 7'h5B;
    localparam logic [6:0] ADDR_SYNTH_TEST  = 7'h5C;
    // reset values
    localparam logic [7:0] RST_MODEM_TEST   = 8'h00;
    localparam logic [7:0] RST_CP_TEST      = 8'h00;
    localparam logic [7:0] RST_CP_TRIM      = 8'h80;
    localparam logic [7:0] RST_DIV_TRIM     = 8'h00;
    localparam logic [7:0] RST_VCO_TRIM     = 8'h03;
    localparam logic [7:0] RST_VCO_CAL      = 8'h00;
    localparam logic [7:0] RST_SYNTH_TEST   = 8'h0E;
    // modem test fields
    localparam int MT_BCR_BYP    = 7;
    localparam int MT_SLIC_BYP   = 6;
    localparam int MT_DITH_TYPE  = 5;
    localparam int MT_OSC_DIS    = 4;
    localparam int MT_OOK_TH     = 3;
    localparam int MT_REF_SEL    = 2;
    localparam int MT_REF_INV    = 1;
    localparam int MT_DISC_TOGG  = 0;
    // charge pump test fields
    localparam int CP_PFD_RST    = 7;
    localparam int CP_FB_RST     = 6;
    localparam int CP_FORCE_UP   = 5;
    localparam int CP_FORCE_DN   = 4;
    localparam int CP_DC_ONLY    = 3;
    localparam int CP_DC_CUR_HI  = 2;
    // charge pump trim fields
    localparam int CT_GAIN_HI    = 7;
    localparam int CT_GAIN_LO    = 6;
    localparam int CT_CORR_OV    = 5;
    localparam int CT_CORR_HI    = 4;
    // divider trim fields
    localparam int DT_CORR_BOOST = 7;
    localparam int DT_FB_HC      = 6;
    localparam int DT_D3_LO      = 4;
    localparam int DT_D2_LO      = 2;
    localparam int DT_D15_LO     = 0;
    // vco trim fields
    localparam int VT_CUR_BOOST  = 7;
    localparam int VT_CORR_OV    = 6;
    localparam int VT_CORR_HI    = 5;
    localparam int VT_CORR_LO    = 2;
    localparam int VT_CUR_HI     = 1;
    // vco calibration fields
    localparam int VC_OVR        = 7;
    localparam int VC_VAL_HI     = 6;
    // synthesizer test fields
    localparam int ST_DITH_EN    = 7;
    localparam int ST_VCO_TYPE   = 6;
    localparam int ST_OPEN_LOOP  = 5;
    localparam int ST_MODULUS    = 4;
    localparam int ST_ORDER_HI   = 3;
    localparam int ST_ORDER_LO   = 2;
    localparam int ST_RST_MODE   = 1;
    localparam int ST_RST        = 0;
    // forced values in boost window (transmit or pre-transmit calibration)
    localparam logic [3:0] VCO_CORR_BOOST = 4'hF;
    localparam logic [1:0] VCO_CUR_BOOST  = 2'h3;
    // ook preamble bit counts
    localparam logic [3:0] OOK_TH_LONG    = 4'h8;
    localparam logic [3:0] OOK_TH_SHORT   = 4'h4;
    // modulus choices
    localparam logic [16:0] MODULUS_DEC   = 17'h0FA00;
    localparam logic [16:0] MODULUS_BIN   = 17'h10000;
    // delta-sigma order encoding
    typedef enum logic [1:0] {
        SMT_ORDER_ZERO  = 2'h0,
        SMT_ORDER_FIRST = 2'h1,
        SMT_ORDER_SECOND = 2'h2,
        SMT_ORDER_MASH  = 2'h3
    } smt_order_t;
endpackage : smt_pkg

// [testbench/smt_regs_monitor.sv]
// checker: control outputs and overrides of the test register bank
`timescale 1ns/100ps
module smt_regs_monitor (
    // clock and reset
    input wire logic        clk_sys,
    input wire logic        resetn,
    // register access
    input wire logic        reg_wr,
    input wire logic [6:0]  reg_addr,
    input wire logic [7:0]  reg_wdata,
    // status and controls
    input wire logic        tx_mode,
    input wire logic        bcr_comp_bypass,
    input wire logic        osc_detect_en,
    input wire logic [3:0]  ook_th_bits,
    input wire logic        ds_ref_invert,
    input wire logic        disc_toggle_en,
    input wire logic        cp_force_up,
    input wire logic        cp_force_dn,
    input wire logic [1:0]  vco_cur,
    input wire logic [6:0]  vco_cal,
    input wire logic [16:0] ds_modulus
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!resetn);
    logic w56, w57, w5a, w5b, w5c;
    assign w56 = reg_wr && reg_addr == smt_pkg::ADDR_MODEM_TEST;
    assign w57 = reg_wr && reg_addr == smt_pkg::ADDR_CP_TEST;
    assign w5a = reg_wr && reg_addr == smt_pkg::ADDR_VCO_TRIM;
    assign w5b = reg_wr && reg_addr == smt_pkg::ADDR_VCO_CAL;
    assign w5c = reg_wr && reg_addr == smt_pkg::ADDR_SYNTH_TEST;
    // boost set, then transmit held with no rewrite
    sequence s_cur_boost;
        w5a && reg_wdata[7] ##1 (tx_mode && !w5a) [*4];
    endsequence
    // a write with no second write to the same register right behind it
    sequence s_mt_write;
        w56 ##1 !w56;
    endsequence
    sequence s_cp_write;
        w57 ##1 !w57;
    endsequence
    sequence s_cal_write;
        w5b && reg_wdata[7] ##1 !w5b;
    endsequence
    sequence s_st_write;
        w5c ##1 !w5c;
    endsequence
    chk_bcr_bypass: assert property (s_mt_write |-> ##1
        bcr_comp_bypass == $past(reg_wdata[7], 2))
        else $error("bypass does not follow write");
    chk_osc_detect: assert property (s_mt_write |-> ##1
        osc_detect_en == !$past(reg_wdata[4], 2))
        else $error("detect enable not inverse of bit");
    chk_ook_count: assert property (s_mt_write |-> ##1
        ook_th_bits == ($past(reg_wdata[3], 2) ? 4'h8 : 4'h4))
        else $error("threshold bit count wrong");
    chk_ref_invert: assert property (s_mt_write |-> ##1
        ds_ref_invert == $past(reg_wdata[1], 2))
        else $error("reference inversion wrong");
    chk_disc_toggle: assert property (s_mt_write |-> ##1
        disc_toggle_en == $past(reg_wdata[0], 2))
        else $error("toggle enable wrong");
    chk_pump_force: assert property (s_cp_write |-> ##1
        {cp_force_up, cp_force_dn} == $past(reg_wdata[5:4], 2))
        else $error("pump force bits wrong");
    chk_cur_boost: assert property (s_cur_boost |-> vco_cur == 2'h3)
        else $error("current trim not boosted");
    chk_cal_override: assert property (s_cal_write |-> ##1
        vco_cal == $past(reg_wdata[6:0], 2))
        else $error("calibration override not applied");
    chk_ds_modulus: assert property (s_st_write |-> ##1
        ds_modulus == ($past(reg_wdata[4], 2) ? smt_pkg::MODULUS_BIN : smt_pkg::MODULUS_DEC))
        else $error("modulus wrong");
endmodule : smt_regs_monitor

bind smt_regs smt_regs_monitor smt_regs_monitor_i (.clk_sys, .resetn, .reg_wr, .reg_addr,
    .reg_wdata, .tx_mode, .bcr_comp_bypass, .osc_detect_en, .ook_th_bits, .ds_ref_invert,
    .disc_toggle_en, .cp_force_up, .cp_force_dn, .vco_cur, .vco_cal, .ds_modulus);

// [testbench/tb.sv]
// testbench: register bank scenarios
`timescale 1ns/100ps
module tb;
    logic        clk_sys, resetn, reg_wr, reg_rd, vco_cal_done, tx_mode, vco_cal_pre_tx;
    logic [6:0]  reg_addr, vco_cal_auto, vco_cal;
    logic [7:0]  reg_wdata, reg_rdata;
    logic [4:0]  cp_corr_auto, cp_corr;
    logic        bcr_comp_bypass, slicer_comp_bypass, dither_signed, osc_detect_en;
    logic        ds_ref_from_xtal, ds_ref_invert, disc_toggle_en, pfd_reset, fb_div_reset;
    logic        cp_force_up, cp_force_dn, cp_dc_only, fb_div_high_current, vco_corr_override;
    logic        ds_dither_en, open_loop, ds_reset_mode, ds_reset;
    logic [3:0]  ook_th_bits, vco_corr;
    logic [2:0]  cp_dc_current;
    logic [1:0]  cp_gain, div_three_trim, div_two_trim, div_one_half_trim, vco_cur, ds_order;
    logic [16:0] ds_modulus;
    int          n_errors, check_count;

    smt_regs smt_regs_i (.*);

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e)
        begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
        @(posedge clk_sys);
    endtask : wr
    task automatic rd(input logic [6:0] a, input logic [7:0] e, input string nm);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd   <= 1'b0;
        @(posedge clk_sys);
        chk(nm, e, reg_rdata);
    endtask : rd
    task automatic sc_reset;
        logic [7:0] tab [7] = '{8'h00, 8'h00, 8'h80, 8'h00, 8'h03, 8'h00, 8'h0E};
        for (int i = 0; i < 7; i++)
            rd(7'h56 + 7'(i), tab[i], "reset read");
        chk("reset out", 9'h14B, {osc_detect_en, ook_th_bits, cp_gain, vco_cur});
    endtask : sc_reset
    task automatic sc_modem;
        logic [7:0] g;
        for (int i = 0; i < 8; i++)
        begin
            wr(smt_pkg::ADDR_MODEM_TEST, 8'h01 << i);
            @(posedge clk_sys);
            g = {bcr_comp_bypass, slicer_comp_bypass, dither_signed, !osc_detect_en,
                ook_th_bits == 4'h8, ds_ref_from_xtal, ds_ref_invert, disc_toggle_en};
            chk("mt hi", 4'(8'h01 << i >> 4), g[7:4]);
            chk("modem lo", 4'(8'h01 << i), g[3:0]);
            rd(smt_pkg::ADDR_MODEM_TEST, 8'h01 << i, "modem read");
        end
    endtask : sc_modem
    task automatic sc_pump;
        logic [7:0] v;
        for (int i = 0; i < 2; i++)
        begin
            v = i ? 8'hD2 : 8'h2D;
            wr(smt_pkg::ADDR_CP_TEST, v);
            @(posedge clk_sys);
            chk("pump", v, {pfd_reset, fb_div_reset, cp_force_up, cp_force_dn, cp_dc_only,
                cp_dc_current});
        end
        cp_corr_auto <= 5'h15;
        wr(smt_pkg::ADDR_CP_TRIM, 8'h40);
        repeat (4) @(posedge clk_sys);
        chk("gain live", 7'h35, {cp_gain, cp_corr});
        rd(smt_pkg::ADDR_CP_TRIM, 8'h55, "trim live");
        wr(smt_pkg::ADDR_CP_TRIM, 8'hEA);
        @(posedge clk_sys);
        chk("gain ovr", 7'h6A, {cp_gain, cp_corr});
        rd(smt_pkg::ADDR_CP_TRIM, 8'hEA, "trim ovr");
    endtask : sc_pump
    task automatic sc_vco;
        wr(smt_pkg::ADDR_DIV_TRIM, 8'h5B);
        @(posedge clk_sys);
        chk("div trim", 7'h5B, {fb_div_high_current, div_three_trim, div_two_trim,
            div_one_half_trim});
        wr(smt_pkg::ADDR_VCO_TRIM, 8'h6A);
        @(posedge clk_sys);
        chk("vco trim", 7'h6A, {vco_corr_override, vco_corr, vco_cur});
        wr(smt_pkg::ADDR_DIV_TRIM, 8'h80);
        tx_mode <= 1'b1;
        wr(smt_pkg::ADDR_VCO_TRIM, 8'hEA);
        repeat (3) @(posedge clk_sys);
        chk("tx boost", 7'h7F, {vco_corr_override, vco_corr, vco_cur});
        tx_mode        <= 1'b0;
        vco_cal_pre_tx <= 1'b1;
        repeat (4) @(posedge clk_sys);
        chk("cal boost", 7'h7F, {vco_corr_override, vco_corr, vco_cur});
        vco_cal_pre_tx <= 1'b0;
        repeat (4) @(posedge clk_sys);
        chk("boost off", 7'h6A, {vco_corr_override, vco_corr, vco_cur});
        vco_cal_auto <= 7'h2B;
        vco_cal_done <= 1'b1;
        repeat (6) @(posedge clk_sys);
        chk("cal live", 7'h2B, vco_cal);
        rd(smt_pkg::ADDR_VCO_CAL, 8'hAB, "cal done");
        wr(smt_pkg::ADDR_VCO_CAL, 8'h91);
        @(posedge clk_sys);
        chk("cal ovr", 7'h11, vco_cal);
        rd(smt_pkg::ADDR_VCO_CAL, 8'h91, "cal ovr read");
    endtask : sc_vco
    task automatic sc_synth;
        logic [7:0] v;
        for (int i = 0; i < 4; i++)
        begin
            v = {i[0], 1'b1, !i[0], i[1], 2'(i), i[1], !i[1]};
            wr(smt_pkg::ADDR_SYNTH_TEST, v);
            @(posedge clk_sys);
            chk("synth", {v[7], v[5], v[3:0]}, {ds_dither_en, open_loop, ds_order,
                ds_reset_mode, ds_reset});
            chk("modulus", v[4] ? 17'h10000 : 17'h0FA00, ds_modulus);
            rd(smt_pkg::ADDR_SYNTH_TEST, v & 8'hBF, "synth read");
        end
        wr(7'h60, 8'hFF);
        rd(7'h60, 8'h00, "unmapped");
    endtask : sc_synth
    task automatic wrap_up;
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : wrap_up

    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    initial
    begin
        {resetn, reg_wr, reg_rd, vco_cal_done, tx_mode, vco_cal_pre_tx} = '0;
        {reg_addr, reg_wdata, cp_corr_auto, vco_cal_auto} = '0;
        n_errors    = 0;
        check_count = 0;
        repeat (6) @(posedge clk_sys);
        resetn <= 1'b1;
        @(posedge clk_sys);
        sc_reset;
        sc_modem;
        sc_pump;
        sc_vco;
        sc_synth;
        wrap_up;
    end
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        n_errors++;
        wrap_up;
    end
endmodule : tb
